/* File: test/power_state_supply_control_bench.sv */
/*
  Self-checking bench of the supply control block with a regulator model.
  Assumes pssc_cfg.svh offsets and the one-cycle APB access of the block.
*/
`timescale 1ns/1ps
`include "pssc_cfg.svh"
module power_state_supply_control_bench;
  logic pclk, presetn, psel, penable, pwrite, wake_pin;
  logic [7:0] paddr, ramp;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, core_en, ana_en, pll_en, io_en, core_pfm, ana_pfm, tile_off;
  logic [2:0] state_code;
  logic [3:0] pgood_in;
  int n_errors, checks_done;

  always #25 pclk = ~pclk;

  pssc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wake_pin(wake_pin), .pgood_in(pgood_in),
    .core_converter_en(core_en), .analogue_converter_en(ana_en),
    .pll_supply_regulator_en(pll_en), .io_supply_output_en(io_en),
    .core_converter_pfm(core_pfm), .analogue_converter_pfm(ana_pfm),
    .tile_clk_off(tile_off), .state_code(state_code));

  pssc_supply_model i_sup (.pclk(pclk), .presetn(presetn),
    .en({io_en, pll_en, ana_en, core_en}), .ramp(ramp), .pgood(pgood_in));

  // Outputs packed as the config bits 14, 9, 8, 5, 4, 1, 0
  function automatic logic [31:0] outs();
    return 32'({tile_off, ana_pfm, core_pfm, io_en, pll_en, ana_en, core_en});
  endfunction

  function automatic logic [31:0] cfg_outs(input logic [31:0] c);
    return 32'({c[14], c[9], c[8], c[5], c[4], c[1], c[0]});
  endfunction

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic timeout(input string what);
    n_errors++;
    $display("[ERR] %s expected done seen timeout", what);
    give_verdict();
  endtask

  // Let the edge's updates land before looking
  task automatic tick();
    @(posedge pclk);
    #1;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) timeout("pready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic e;
    apb(1'b1, a, d, rd, e);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic e;
    apb(1'b0, a, 32'h0000_0000, rd, e);
    check(what, exp, rd);
  endtask

  task automatic wait_st(input logic [2:0] s);
    int n;
    n = 0;
    while (state_code !== s && n < 3000) begin
      tick();
      n++;
    end
    if (state_code !== s) timeout("state");
  endtask

  // Cycles spent in state s, counted from its first sample
  task automatic cnt_st(input logic [2:0] s, output int n);
    n = 0;
    do begin
      n++;
      tick();
    end while (state_code === s && n < 3000);
  endtask

  task automatic t_boot();
    wr(`PSSC_OFS_WAKE2, 32'h0003_0033);
    tick();
    check("state wake2", 32'h3, 32'(state_code));
    wait_st(3'h5);
    check("awake outs", 32'h0F, outs());
    $display("t_boot done");
  endtask

  task automatic t_regs();
    logic [31:0] rd;
    logic e;
    rd_chk("awake reset", `PSSC_OFS_AWAKE, 32'h0000_0033);
    rd_chk("sleep1 reset", `PSSC_OFS_SLEEP1, 32'h0010_0022);
    rd_chk("sleep2 reset", `PSSC_OFS_SLEEP2, 32'h0010_0002);
    rd_chk("wake2 dwell", `PSSC_OFS_WAKE2, 32'h0003_0033);
    wr(`PSSC_OFS_AWAKE, 32'hFFFF_FFFF);
    tick();
    check("awake all set", 32'h7F, outs());
    rd_chk("awake mask", `PSSC_OFS_AWAKE, 32'h0000_4333);
    wr(`PSSC_OFS_AWAKE, 32'h0000_0000);
    tick();
    check("awake all clear", 32'h02, outs());
    rd_chk("analogue fixed", `PSSC_OFS_AWAKE, 32'h0000_0002);
    wr(`PSSC_OFS_AWAKE, 32'h0000_0033);
    wr(`PSSC_OFS_SLEEP1, 32'hFFFF_FFFF);
    rd_chk("dwell mask", `PSSC_OFS_SLEEP1, 32'h001F_4333);
    apb(1'b0, 8'h40, 32'h0000_0000, rd, e);
    check("unmapped error", 32'h1, 32'(e));
    $display("t_regs done");
  endtask

  task automatic t_sleep(input logic [4:0] dw1);
    int n;
    logic [31:0] rd;
    logic e;
    wr(`PSSC_OFS_SLEEP1, {11'h000, dw1, 16'h4122});
    wr(`PSSC_OFS_SLEEP2, 32'h0003_0201);
    wr(`PSSC_OFS_CTRL, 32'h0000_0002);
    wait_st(3'h6);
    check("sleep1 outs", cfg_outs(32'h0000_4122), outs());
    cnt_st(3'h6, n);
    check("sleep1 cycles", 32'h0000_0001 << dw1, 32'(n));
    // Analogue enable reads one although the write cleared it
    check("sleep2 outs", cfg_outs(32'h0003_0203), outs());
    cnt_st(3'h7, n);
    check("sleep2 cycles", 32'h0000_0008, 32'(n));
    check("asleep", 32'h1, 32'(state_code));
    apb(1'b0, `PSSC_OFS_CTRL, 32'h0000_0000, rd, e);
    check("initiate cleared", 32'h0, 32'(rd[1]));
    wr(`PSSC_OFS_CTRL, 32'h0000_0002);
    repeat (4) tick();
    check("initiate refused", 32'h1, 32'(state_code));
    $display("t_sleep done");
  endtask

  task automatic t_wake(input logic [7:0] rmp, input logic [4:0] dw, input int lo);
    int n;
    wr(`PSSC_OFS_WAKE2, {11'h000, dw, 16'h0033});
    @(posedge pclk);
    ramp <= rmp;
    wake_pin <= 1'b1;
    // One-cycle pulse, dropped on an edge so it cannot rewake later
    @(posedge pclk);
    wake_pin <= 1'b0;
    wait_st(3'h3);
    cnt_st(3'h3, n);
    check("wake2 stay", 32'h1, 32'(n >= lo && n < lo + 8));
    check("awake wait", 32'h4, 32'(state_code));
    tick();
    check("awake", 32'h5, 32'(state_code));
    $display("t_wake done");
  endtask

  task automatic t_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    tick();
    check("reset state", 32'h0, 32'(state_code));
    check("reset outs", 32'h0F, outs());
    @(posedge pclk);
    presetn <= 1'b1;
    tick();
    check("first state", 32'h3, 32'(state_code));
    rd_chk("wake2 reset", `PSSC_OFS_WAKE2, 32'h0010_0033);
    $display("t_reset done");
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    wake_pin = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    ramp = 8'h02;
    n_errors = 0;
    checks_done = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_boot();
    t_regs();
    t_sleep(5'h02);
    t_wake(8'h02, 5'h05, 32);
    t_sleep(5'h00);
    t_wake(8'h28, 5'h00, 40);
    t_reset();
    give_verdict();
  end
endmodule

/* File: test/pssc_supply_model.sv */
/*
  Behavioural model of the regulators behind the supply control block.
  Assumes the enables are levels in the pclk domain.
*/
`timescale 1ns/1ps
module pssc_supply_model (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic [3:0] en, // Enables: io, pll, analogue, core
  input wire logic [7:0] ramp, // Cycles from enable to good
  output logic [3:0] pgood // Power good per supply
);
  logic [7:0] age_r [4];
  // good report
  // Good only after the ramp; a disabled supply drops at once
  always_ff @(posedge pclk or negedge presetn) begin
    for (int i = 0; i < 4; i++) begin
      if (!presetn || !en[i]) begin
        age_r[i] <= 8'h00;
        pgood[i] <= 1'b0;
      end else begin
        age_r[i] <= (age_r[i] == 8'hFF) ? age_r[i] : age_r[i] + 8'h01;
        pgood[i] <= (age_r[i] >= ramp);
      end
    end
  end
endmodule

/* File: verilog/pssc_cfg.svh */
/*
  Offsets, field positions, reset values and write masks of the
  supply control block. Assumes APB byte addresses, one word per register.
*/
`ifndef PSSC_CFG_SVH
`define PSSC_CFG_SVH

`define PSSC_OFS_CTRL 8'h00
`define PSSC_OFS_WAKE2 8'h14
`define PSSC_OFS_AWAKE 8'h18
`define PSSC_OFS_SLEEP1 8'h1C
`define PSSC_OFS_SLEEP2 8'h20
`define PSSC_OFS_STATUS 8'h24

`define PSSC_BIT_CORE_EN 0
`define PSSC_BIT_ANA_EN 1
`define PSSC_BIT_PLL_EN 4
`define PSSC_BIT_IO_EN 5
`define PSSC_BIT_CORE_PFM 8
`define PSSC_BIT_ANA_PFM 9
`define PSSC_BIT_TILE_OFF 14
`define PSSC_DWELL_HI 20
`define PSSC_DWELL_LO 16
`define PSSC_STATE_HI 18
`define PSSC_STATE_LO 16
`define PSSC_BIT_SLEEP_GO 1

`define PSSC_RST_WAKE2 32'h0010_0033
`define PSSC_RST_AWAKE 32'h0000_0033
`define PSSC_RST_SLEEP1 32'h0010_0022
`define PSSC_RST_SLEEP2 32'h0010_0002
`define PSSC_WMASK_DWELL 32'h001F_4331
`define PSSC_WMASK_AWAKE 32'h0000_4331
`define PSSC_RO_ONES 32'h0000_0002
`define PSSC_CFG_ASLEEP 32'h0000_0000
`define PSSC_CFG_WAKE1 32'h0000_0020

`endif

/* File: verilog/pssc_pkg.sv */
/*
  Types of the supply control block: sequencer states, one-hot.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package pssc_pkg;
  typedef enum logic [7:0] {
    ST_RESET = 8'h01,
    ST_ASLEEP = 8'h02,
    ST_WAKE_PHASE_ONE = 8'h04,
    ST_WAKE_PHASE_TWO = 8'h08,
    ST_AWAKE_WAIT = 8'h10,
    ST_AWAKE = 8'h20,
    ST_SLEEP_PHASE_ONE = 8'h40,
    ST_SLEEP_PHASE_TWO = 8'h80
  } pssc_state_t;
endpackage

/* File: verilog/pssc_top.sv */
/*
  Power state supply control: per-state supply configuration registers
  on APB and the sequencer that applies them to the regulators.
  Assumes pgood and wake inputs come from outside the pclk domain and
  that the sequencer clock is pclk.
*/
// Functional notes
// - Stay in wake phase two for dwell
// - Leave wake two only when supplies good
// - Dwell field is log2 of cycles
// - Sleep phases stay their dwell, then advance
// - Awake state driven from awake register
// - Bit 14 gates tile clock off
// - Bit 9 selects analogue converter PFM
// - Bit 8 selects core converter PFM
// - Bit 5 enables IO supply output
// - Bit 4 enables PLL supply regulator
// - Bit 1 read-only, reads one
// - Bit 0 enables core converter
// - Wake two resets all supplies on
// - Sleep one resets IO and analogue on
// - Sleep two resets analogue only on
// - State exposed as three-bit code
// - Sleep initiate self-clears, only when awake
// - Dwell counted on the sequencer clock
`timescale 1ns/1ps
`include "pssc_cfg.svh"

module pssc_top (
  input wire logic pclk, // APB and sequencer clock, 20 MHz
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic wake_pin, // Asynchronous wake request, high
  input wire logic [3:0] pgood_in, // Power good: io, pll, analogue, core
  output logic core_converter_en, // Core converter enable
  output logic analogue_converter_en, // Analogue converter enable
  output logic pll_supply_regulator_en, // PLL supply regulator enable
  output logic io_supply_output_en, // IO supply output enable
  output logic core_converter_pfm, // Core converter in PFM
  output logic analogue_converter_pfm, // Analogue converter in PFM
  output logic tile_clk_off, // Tile clock gated off
  output logic [2:0] state_code // Current sequencer state
);

  pssc_pkg::pssc_state_t st_r, st_nxt;
  logic [31:0] wk2_r, aw_r, sl1_r, sl2_r, act_r, cfg_nxt, cnt_r, lim, rd_nxt;
  logic sleep_go_r, wr_en, setup, mapped, dwell_done, pg_ok;
  logic [1:0] wake_sync_r;
  logic [3:0] pg_meta_r, pg_r;
  logic [2:0] code_nxt;

  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite & pready;
  assign mapped = (paddr == `PSSC_OFS_CTRL) | (paddr == `PSSC_OFS_WAKE2) |
                  (paddr == `PSSC_OFS_AWAKE) | (paddr == `PSSC_OFS_SLEEP1) |
                  (paddr == `PSSC_OFS_SLEEP2) | (paddr == `PSSC_OFS_STATUS);

  // Two-flop synchronisers for pins from the regulator side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_sync_r <= 2'h0;
      pg_meta_r <= 4'h0;
      pg_r <= 4'h0;
    end else begin
      wake_sync_r <= {wake_sync_r[0], wake_pin};
      pg_meta_r <= pgood_in;
      pg_r <= pg_meta_r;
    end
  end

  // Config registers; bit 1 is forced to one on every write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wk2_r <= `PSSC_RST_WAKE2;
      aw_r <= `PSSC_RST_AWAKE;
      sl1_r <= `PSSC_RST_SLEEP1;
      sl2_r <= `PSSC_RST_SLEEP2;
    end else if (wr_en) begin
      if (paddr == `PSSC_OFS_WAKE2) begin
        wk2_r <= (pwdata & `PSSC_WMASK_DWELL) | `PSSC_RO_ONES;
      end
      if (paddr == `PSSC_OFS_AWAKE) begin
        aw_r <= (pwdata & `PSSC_WMASK_AWAKE) | `PSSC_RO_ONES;
      end
      if (paddr == `PSSC_OFS_SLEEP1) begin
        sl1_r <= (pwdata & `PSSC_WMASK_DWELL) | `PSSC_RO_ONES;
      end
      if (paddr == `PSSC_OFS_SLEEP2) begin
        sl2_r <= (pwdata & `PSSC_WMASK_DWELL) | `PSSC_RO_ONES;
      end
    end
  end

  // self-clearing initiate
  // A write outside awake is dropped; the leaving edge clears the bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_go_r <= 1'b0;
    end else if (wr_en && paddr == `PSSC_OFS_CTRL && pwdata[`PSSC_BIT_SLEEP_GO] &&
                 st_r == pssc_pkg::ST_AWAKE && st_nxt == pssc_pkg::ST_AWAKE) begin
      sleep_go_r <= 1'b1;
    end else if (st_r != pssc_pkg::ST_AWAKE || st_nxt != pssc_pkg::ST_AWAKE) begin
      sleep_go_r <= 1'b0;
    end
  end

  // limit is two to the field, minus one
  assign lim = (32'h0000_0001 << act_r[`PSSC_DWELL_HI:`PSSC_DWELL_LO]) - 32'h0000_0001;
  assign dwell_done = (cnt_r == lim);

  // every enabled supply must be good
  assign pg_ok = (~act_r[`PSSC_BIT_CORE_EN] | pg_r[0]) &
                 (~act_r[`PSSC_BIT_ANA_EN] | pg_r[1]) &
                 (~act_r[`PSSC_BIT_PLL_EN] | pg_r[2]) &
                 (~act_r[`PSSC_BIT_IO_EN] | pg_r[3]);

  // Next state of the sequencer
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      pssc_pkg::ST_RESET, pssc_pkg::ST_WAKE_PHASE_ONE: begin
        st_nxt = pssc_pkg::ST_WAKE_PHASE_TWO;
      end
      pssc_pkg::ST_ASLEEP: begin
        if (wake_sync_r[1]) begin
          st_nxt = pssc_pkg::ST_WAKE_PHASE_ONE;
        end
      end
      pssc_pkg::ST_WAKE_PHASE_TWO: begin
        if (dwell_done && pg_ok) begin
          st_nxt = pssc_pkg::ST_AWAKE_WAIT;
        end
      end
      pssc_pkg::ST_AWAKE_WAIT: begin
        st_nxt = pssc_pkg::ST_AWAKE;
      end
      pssc_pkg::ST_AWAKE: begin
        if (sleep_go_r) begin
          st_nxt = pssc_pkg::ST_SLEEP_PHASE_ONE;
        end
      end
      pssc_pkg::ST_SLEEP_PHASE_ONE: begin
        if (dwell_done) begin
          st_nxt = pssc_pkg::ST_SLEEP_PHASE_TWO;
        end
      end
      pssc_pkg::ST_SLEEP_PHASE_TWO: begin
        if (dwell_done) begin
          st_nxt = pssc_pkg::ST_ASLEEP;
        end
      end
      default: begin
        st_nxt = pssc_pkg::ST_RESET;
      end
    endcase
  end

  // Config applied in the next state; awake tracks its register live
  always_comb begin
    cfg_nxt = `PSSC_CFG_ASLEEP;
    code_nxt = 3'h0;
    case (st_nxt)
      pssc_pkg::ST_RESET: begin
        cfg_nxt = wk2_r;
        code_nxt = 3'h0;
      end
      pssc_pkg::ST_ASLEEP: begin
        cfg_nxt = `PSSC_CFG_ASLEEP;
        code_nxt = 3'h1;
      end
      pssc_pkg::ST_WAKE_PHASE_ONE: begin
        cfg_nxt = `PSSC_CFG_WAKE1;
        code_nxt = 3'h2;
      end
      pssc_pkg::ST_WAKE_PHASE_TWO: begin
        cfg_nxt = wk2_r;
        code_nxt = 3'h3;
      end
      pssc_pkg::ST_AWAKE_WAIT: begin
        cfg_nxt = wk2_r;
        code_nxt = 3'h4;
      end
      pssc_pkg::ST_AWAKE: begin
        cfg_nxt = aw_r;
        code_nxt = 3'h5;
      end
      pssc_pkg::ST_SLEEP_PHASE_ONE: begin
        cfg_nxt = sl1_r;
        code_nxt = 3'h6;
      end
      pssc_pkg::ST_SLEEP_PHASE_TWO: begin
        cfg_nxt = sl2_r;
        code_nxt = 3'h7;
      end
      default: begin
        cfg_nxt = `PSSC_CFG_ASLEEP;
        code_nxt = 3'h0;
      end
    endcase
  end

  // State, applied config and its code all move on the same edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= pssc_pkg::ST_RESET;
      act_r <= `PSSC_RST_WAKE2;
      state_code <= 3'h0;
    end else begin
      st_r <= st_nxt;
      act_r <= cfg_nxt;
      state_code <= code_nxt;
    end
  end

  // dwell counts pclk cycles
  // Counter restarts on every state change and holds once done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 32'h0000_0000;
    end else if (st_nxt != st_r) begin
      cnt_r <= 32'h0000_0000;
    end else if (!dwell_done) begin
      cnt_r <= cnt_r + 32'h0000_0001;
    end
  end

  // Supply outputs straight from flops, fed by the next config
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_converter_en <= 1'b1;
      analogue_converter_en <= 1'b1;
      pll_supply_regulator_en <= 1'b1;
      io_supply_output_en <= 1'b1;
      core_converter_pfm <= 1'b0;
      analogue_converter_pfm <= 1'b0;
      tile_clk_off <= 1'b0;
    end else begin
      core_converter_en <= cfg_nxt[`PSSC_BIT_CORE_EN];
      analogue_converter_en <= cfg_nxt[`PSSC_BIT_ANA_EN];
      pll_supply_regulator_en <= cfg_nxt[`PSSC_BIT_PLL_EN];
      io_supply_output_en <= cfg_nxt[`PSSC_BIT_IO_EN];
      core_converter_pfm <= cfg_nxt[`PSSC_BIT_CORE_PFM];
      analogue_converter_pfm <= cfg_nxt[`PSSC_BIT_ANA_PFM];
      tile_clk_off <= cfg_nxt[`PSSC_BIT_TILE_OFF];
    end
  end

  // Read mux; status shows the applied supplies and the state
  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (paddr)
      `PSSC_OFS_CTRL: rd_nxt = {30'h0, sleep_go_r, 1'b0};
      `PSSC_OFS_WAKE2: rd_nxt = wk2_r;
      `PSSC_OFS_AWAKE: rd_nxt = aw_r;
      `PSSC_OFS_SLEEP1: rd_nxt = sl1_r;
      `PSSC_OFS_SLEEP2: rd_nxt = sl2_r;
      `PSSC_OFS_STATUS: rd_nxt = {13'h0, state_code, act_r[15:0] & 16'h4333};
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // One wait-free access phase: answer captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      prdata <= (setup & ~pwrite) ? rd_nxt : 32'h0000_0000;
    end
  end

  chk_wake2_min_dwell: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r == pssc_pkg::ST_WAKE_PHASE_TWO && st_nxt != st_r) |-> cnt_r == lim)
    else $error("wake two left before dwell");
  chk_wake2_pgood: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r == pssc_pkg::ST_WAKE_PHASE_TWO && st_nxt != st_r) |-> pg_ok)
    else $error("wake two left without power good");
  chk_dwell_length: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r == pssc_pkg::ST_SLEEP_PHASE_ONE && act_r[20:16] == 5'h0) |=>
    st_r == pssc_pkg::ST_SLEEP_PHASE_TWO)
    else $error("one-cycle dwell not honoured");
  chk_sleep_advance: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r == pssc_pkg::ST_SLEEP_PHASE_TWO && dwell_done) |=> st_r == pssc_pkg::ST_ASLEEP)
    else $error("sleep two did not advance");
  chk_awake_cfg: assert property (@(posedge pclk) disable iff (!presetn)
    st_nxt == pssc_pkg::ST_AWAKE |=> core_converter_en == $past(aw_r[0]) &&
    tile_clk_off == $past(aw_r[14]))
    else $error("awake outputs not from awake register");
  chk_tile_gate: assert property (@(posedge pclk) disable iff (!presetn)
    st_nxt == pssc_pkg::ST_SLEEP_PHASE_TWO |=> tile_clk_off == $past(sl2_r[14]))
    else $error("tile gate wrong in sleep two");
  chk_io_enable: assert property (@(posedge pclk) disable iff (!presetn)
    st_nxt == pssc_pkg::ST_SLEEP_PHASE_ONE |=> io_supply_output_en == $past(sl1_r[5]))
    else $error("io enable wrong in sleep one");
  chk_ana_ro: assert property (@(posedge pclk) disable iff (!presetn)
    wk2_r[1] && aw_r[1] && sl1_r[1] && sl2_r[1])
    else $error("analogue enable bit not one");
  chk_sleep_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (sleep_go_r && st_r == pssc_pkg::ST_AWAKE) |=>
    (!sleep_go_r && st_r == pssc_pkg::ST_SLEEP_PHASE_ONE))
    else $error("initiate bit did not start and clear");
  chk_state_code: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == pssc_pkg::ST_AWAKE |-> state_code == 3'h5)
    else $error("awake code wrong");
  chk_go_only_awake: assert property (@(posedge pclk) disable iff (!presetn)
    sleep_go_r |-> st_r == pssc_pkg::ST_AWAKE) else $error("initiate set outside awake");
  cov_reach_awake: cover property (@(posedge pclk) disable iff (!presetn)
    st_r == pssc_pkg::ST_AWAKE_WAIT ##1 st_r == pssc_pkg::ST_AWAKE);
  cov_reach_asleep: cover property (@(posedge pclk) disable iff (!presetn)
    st_r == pssc_pkg::ST_SLEEP_PHASE_TWO ##1 st_r == pssc_pkg::ST_ASLEEP);
  cov_rewake: cover property (@(posedge pclk) disable iff (!presetn)
    st_r == pssc_pkg::ST_ASLEEP ##1 st_r == pssc_pkg::ST_WAKE_PHASE_ONE);
endmodule
